// file: logic/ddp_pkg.sv
package ddp_pkg;

    // Word format
    localparam int          DATA_W     = 12;
    localparam logic [11:0] MSB_MASK   = 12'h800;
    localparam int          CH_I       = 0;
    localparam int          CH_Q       = 1;

    // Pipeline and link timing
    localparam int          LAT_CYC    = 4;
    localparam int          SYS_MHZ    = 100;
    localparam int          LAG_MIN_NS = 2;
    localparam int          LAG_MIN_CYC =
        (LAG_MIN_NS * SYS_MHZ + 999) / 1000;
    localparam int          HALF_CYC   = 4;
    localparam int          IQRST_CYC  = 8;
    localparam int          FIFO_DEPTH = 32;

    // Mode pin and select levels
    localparam logic        MODE_IQ    = 1'b0;
    localparam logic        MODE_DUAL  = 1'b1;
    localparam logic        SEL_I      = 1'b1;

    // Bit positions in the sampled pin vector
    localparam int          PIN_WR_A   = 0;
    localparam int          PIN_WR_B   = 1;
    localparam int          PIN_CLK_A  = 2;
    localparam int          PIN_CLK_B  = 3;
    localparam int          PIN_RST    = 4;
    localparam int          PIN_MODE   = 5;
    localparam int          PIN_BUS_A  = 6;
    localparam int          PIN_BUS_B  = 6 + DATA_W;
    localparam int          PIN_W      = 6 + 2 * DATA_W;

endpackage : ddp_pkg

// file: logic/ddp_link_if.sv
`timescale 1ns/1ps
interface ddp_link_if;
    import ddp_pkg::*;

    logic [DATA_W-1:0] bus_a;
    logic [DATA_W-1:0] bus_b;
    logic              write_strobe_chan_a;
    logic              write_strobe_chan_b;
    logic              update_clock_chan_a;
    logic              update_clock_chan_b;
    logic              interleave_reset;
    logic              mode_sel;

    modport host (
        output bus_a,
        output bus_b,
        output write_strobe_chan_a,
        output write_strobe_chan_b,
        output update_clock_chan_a,
        output update_clock_chan_b,
        output interleave_reset,
        output mode_sel
    );

    modport dev (
        input  bus_a,
        input  bus_b,
        input  write_strobe_chan_a,
        input  write_strobe_chan_b,
        input  update_clock_chan_a,
        input  update_clock_chan_b,
        input  interleave_reset,
        input  mode_sel
    );

endinterface : ddp_link_if

// file: logic/ddp_dev.sv
`timescale 1ns/1ps
module ddp_dev
    import ddp_pkg::*;
#(
    parameter int LAT = LAT_CYC
) (
    input  wire logic               SYS_CLK_I,
    input  wire logic               ARST_N_I,
    ddp_link_if.dev                 LINK,
    output logic [DATA_W-1:0]       DAC_I_O,
    output logic [DATA_W-1:0]       DAC_Q_O,
    output logic [DATA_W-1:0]       DAC_I_TC_O,
    output logic [DATA_W-1:0]       DAC_Q_TC_O,
    output logic [1:0]              UPD_O,
    output logic                    LATCH_CLK_O,
    output logic                    SEL_O,
    output logic                    MODE_DUAL_O
);

    // Elaboration check on pipeline depth
    if (LAT < 1 || LAT > 16) begin : g_lat_chk
        $error("ddp_dev: LAT must lie in 1..16");
    end

    typedef logic [DATA_W-1:0] ddp_word_t;

    typedef struct packed {
        logic [PIN_W-1:0]             s1;
        logic [PIN_W-1:0]             s2;
        logic [PIN_W-1:0]             s3;
        logic [1:0][DATA_W-1:0]       in_lat;
        logic [1:0][DATA_W-1:0]       pre;
        logic [1:0][LAT-1:0][DATA_W-1:0] pipe;
        logic [1:0][DATA_W-1:0]       out_tc;
        logic [1:0]                   upd;
        logic                         sel;
        logic                         div;
        logic                         dual;
    } ddp_dev_st_t;

    // Select starts on I so a fresh start pairs correctly
    localparam ddp_dev_st_t ST_RST = '{sel: SEL_I, default: '0};

    ddp_dev_st_t r_q;
    ddp_dev_st_t r_d;
    logic [PIN_W-1:0] pins;

    // Gather every pin into one vector for the synchroniser
    assign pins = {LINK.bus_b,
                   LINK.bus_a,
                   LINK.mode_sel,
                   LINK.interleave_reset,
                   LINK.update_clock_chan_b,
                   LINK.update_clock_chan_a,
                   LINK.write_strobe_chan_b,
                   LINK.write_strobe_chan_a};

    // Next-state logic
    always_comb begin
        logic [5:0]           rise;
        logic [5:0]           fall;
        logic                 rst_iq;
        logic [1:0]           shift;
        logic [1:0][DATA_W-1:0] src;
        logic [1:0][DATA_W-1:0] bus;
        rise   = '0;
        fall   = '0;
        rst_iq = 1'b0;
        shift  = '0;
        src    = '0;
        bus    = '0;
        r_d    = r_q;

        // Two stages before use; edges seen between s2 and s3
        r_d.s1 = pins;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        rise   = r_q.s2[5:0] & ~r_q.s3[5:0];
        fall   = ~r_q.s2[5:0] & r_q.s3[5:0];
        rst_iq = r_q.s2[PIN_RST];
        bus[CH_I] = r_q.s2[PIN_BUS_A +: DATA_W];
        bus[CH_Q] = r_q.s2[PIN_BUS_B +: DATA_W];
        r_d.upd   = '0;

        // Mode follows the static pin level
        r_d.dual = r_q.s2[PIN_MODE];

        if (r_q.dual == MODE_DUAL) begin
            // Each channel runs on its own strobe and clock
            for (int ch = 0; ch < 2; ch++) begin
                if (rise[PIN_WR_A + ch]) begin
                    r_d.in_lat[ch] = bus[ch];
                end
                if (rise[PIN_CLK_A + ch]) begin
                    shift[ch] = 1'b1;
                    src[ch]   = r_q.in_lat[ch];
                end
            end
            // Park interleave state so a mode change starts clean
            r_d.sel = SEL_I;
            r_d.div = 1'b0;
        end else begin
            // Bus B is never looked at here
            if (rst_iq) begin
                r_d.sel = SEL_I;
                r_d.div = 1'b0;
            end else begin
                if (rise[PIN_WR_A]) begin
                    // Default copy keeps the other latch
                    if (r_q.sel == SEL_I) begin
                        r_d.in_lat[CH_I] = bus[CH_I];
                    end else begin
                        r_d.in_lat[CH_Q] = bus[CH_I];
                    end
                    r_d.sel = ~r_q.sel;
                end
                // Pair moves on toward the latches on the fall
                if (fall[PIN_WR_A]) begin
                    r_d.pre = r_q.in_lat;
                end
                // Shared clock halved; shift on divided rise
                if (rise[PIN_CLK_A]) begin
                    r_d.div = ~r_q.div;
                    if (!r_q.div) begin
                        shift = 2'b11;
                        src   = r_q.pre;
                    end
                end
            end
        end

        // Fixed-depth pipeline gives constant latency
        for (int ch = 0; ch < 2; ch++) begin
            if (shift[ch]) begin
                r_d.pipe[ch][0] = src[ch];
                for (int k = 1; k < LAT; k++) begin
                    r_d.pipe[ch][k] = r_q.pipe[ch][k-1];
                end
                // Offset binary to two's complement: flip MSB
                r_d.out_tc[ch] = r_d.pipe[ch][LAT-1] ^ MSB_MASK;
                r_d.upd[ch]    = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            r_q <= ST_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs taken straight from the state register
    assign DAC_I_O     = r_q.pipe[CH_I][LAT-1];
    assign DAC_Q_O     = r_q.pipe[CH_Q][LAT-1];
    assign DAC_I_TC_O  = r_q.out_tc[CH_I];
    assign DAC_Q_TC_O  = r_q.out_tc[CH_Q];
    assign UPD_O       = r_q.upd;
    assign LATCH_CLK_O = r_q.div;
    assign SEL_O       = r_q.sel;
    assign MODE_DUAL_O = r_q.dual;

endmodule : ddp_dev

// file: logic/ddp_host.sv
`timescale 1ns/1ps
module ddp_fifo #(
    parameter int W     = 24,
    parameter int DEPTH = 32
) (
    input  wire logic          clk_i,
    input  wire logic          arst_n_i,
    input  wire logic [W-1:0]  in_data_i,
    input  wire logic          in_valid_i,
    output logic               in_ready_o,
    output logic [W-1:0]       out_data_o,
    output logic               out_valid_o,
    input  wire logic          out_ready_i
);

    if (DEPTH < 2 || W < 1) begin : g_chk
        $error("ddp_fifo: DEPTH must be 2 or more");
    end

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } ddp_fifo_st_t;

    ddp_fifo_st_t r_q;
    ddp_fifo_st_t r_d;
    logic         push;
    logic         pop;

    // Count is honest; full blocks the writer
    assign in_ready_o  = (r_q.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (r_q.cnt != '0);
    assign out_data_o  = r_q.mem[r_q.rp];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_ready_i & out_valid_o;

    // Pointer wrap works for any depth
    always_comb begin
        r_d = r_q;
        if (push) begin
            r_d.mem[r_q.wp] = in_data_i;
            r_d.wp = (r_q.wp == AW'(DEPTH-1)) ? '0 : r_q.wp + 1'b1;
        end
        if (pop) begin
            r_d.rp = (r_q.rp == AW'(DEPTH-1)) ? '0 : r_q.rp + 1'b1;
        end
        r_d.cnt = r_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

endmodule : ddp_fifo

module ddp_host
    import ddp_pkg::*;
#(
    parameter int HALF  = HALF_CYC,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic                SYS_CLK_I,
    input  wire logic                ARST_N_I,
    input  wire logic                MODE_I,
    input  wire logic                RESYNC_I,
    input  wire logic [2*DATA_W-1:0] PAIR_I,
    input  wire logic                PAIR_VALID_I,
    output logic                     PAIR_READY_O,
    ddp_link_if.host                 LINK
);

    if (HALF < 1 || HALF > 255) begin : g_chk
        $error("ddp_host: HALF must lie in 1..255");
    end

    typedef enum logic [1:0] {
        ST_SYNC = 2'b01,
        ST_RUN  = 2'b10
    } ddp_hst_t;

    typedef struct packed {
        ddp_hst_t          st;
        logic [7:0]        ph;
        logic [7:0]        rcnt;
        logic              wr;
        logic              rst;
        logic              mode;
        logic              slot_q;
        logic [DATA_W-1:0] bus_a;
        logic [DATA_W-1:0] bus_b;
        logic [DATA_W-1:0] hold_i;
        logic [DATA_W-1:0] hold_q;
    } ddp_host_st_t;

    localparam ddp_host_st_t ST_RST =
        '{st: ST_SYNC, rst: 1'b1, default: '0};

    ddp_host_st_t        r_q;
    ddp_host_st_t        r_d;
    logic [2*DATA_W-1:0] f_data;
    logic                f_valid;
    logic                f_pop;

    // Buffer absorbs bursts; full stalls the user side
    ddp_fifo #(
        .W     (2*DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i       (SYS_CLK_I),
        .arst_n_i    (ARST_N_I),
        .in_data_i   (PAIR_I),
        .in_valid_i  (PAIR_VALID_I),
        .in_ready_o  (PAIR_READY_O),
        .out_data_o  (f_data),
        .out_valid_o (f_valid),
        .out_ready_i (f_pop)
    );

    always_comb begin
        logic present;
        present = 1'b0;
        f_pop   = 1'b0;
        r_d     = r_q;
        case (r_q.st)
            ST_SYNC: begin
                // Strobes parked low while pairing is re-fixed
                r_d.wr  = 1'b0;
                r_d.rst = 1'b1;
                r_d.mode = MODE_I;
                // Slot cleared early so the first word out is I
                r_d.slot_q = 1'b0;
                r_d.rcnt = r_q.rcnt + 8'h01;
                if (r_q.rcnt == 8'(IQRST_CYC - 1)) begin
                    r_d.st     = ST_RUN;
                    r_d.rst    = 1'b0;
                    r_d.rcnt   = '0;
                    r_d.ph     = '0;
                    r_d.slot_q = 1'b0;
                    present    = 1'b1;
                end
            end
            ST_RUN: begin
                // Symmetric duty cycle
                if (r_q.ph == 8'(HALF - 1)) begin
                    r_d.ph = '0;
                    r_d.wr = ~r_q.wr;
                    present = r_q.wr;
                end else begin
                    r_d.ph = r_q.ph + 8'h01;
                end
                if (RESYNC_I) begin
                    r_d.st   = ST_SYNC;
                    r_d.rcnt = '0;
                end
            end
            default: begin
                r_d = ST_RST;
            end
        endcase

        // New word set half a period ahead of the write rise
        if (present) begin
            if (r_q.mode == MODE_DUAL || !r_q.slot_q) begin
                if (f_valid) begin
                    f_pop    = 1'b1;
                    r_d.bus_a  = f_data[DATA_W-1:0];
                    r_d.hold_i = f_data[DATA_W-1:0];
                    r_d.hold_q = f_data[2*DATA_W-1:DATA_W];
                    r_d.bus_b  = f_data[2*DATA_W-1:DATA_W];
                end else begin
                    // Underrun repeats the whole last pair, not Q twice
                    r_d.bus_a = r_q.hold_i;
                    r_d.bus_b = r_q.hold_q;
                end
            end else begin
                r_d.bus_a = r_q.hold_q;
            end
            // In IQ mode I then Q alternate at the write rate; dual mode keeps the slot at I
            r_d.slot_q = (r_q.mode == MODE_DUAL) ? 1'b0 : ~r_q.slot_q;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            r_q <= ST_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // Strobe and clock tied: one period, zero skew
    assign LINK.write_strobe_chan_a = r_q.wr;
    assign LINK.write_strobe_chan_b = r_q.wr;
    assign LINK.update_clock_chan_a = r_q.wr;
    assign LINK.update_clock_chan_b = r_q.wr;
    assign LINK.interleave_reset    = r_q.rst;
    assign LINK.mode_sel            = r_q.mode;
    assign LINK.bus_a               = r_q.bus_a;
    assign LINK.bus_b               = r_q.bus_b;

endmodule : ddp_host

// file: dv/ddp_link_checker.sv
`timescale 1ns/1ps
module ddp_link_checker
    import ddp_pkg::*;
(
    input wire logic              SYS_CLK_I,
    input wire logic              ARST_N_I,
    input wire logic              write_strobe_chan_a,
    input wire logic              write_strobe_chan_b,
    input wire logic              update_clock_chan_a,
    input wire logic              update_clock_chan_b,
    input wire logic              interleave_reset,
    input wire logic              mode_sel,
    input wire logic [DATA_W-1:0] DAC_I_O,
    input wire logic [DATA_W-1:0] DAC_Q_O,
    input wire logic [DATA_W-1:0] DAC_I_TC_O,
    input wire logic [DATA_W-1:0] DAC_Q_TC_O,
    input wire logic [1:0]        UPD_O,
    input wire logic              LATCH_CLK_O,
    input wire logic              SEL_O,
    input wire logic              MODE_DUAL_O
);
    // Single domain, so one clocking and one disable for all
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);

    // Five cycles leave room for the pin synchroniser
    property p_rst_div_low;
        interleave_reset[*5] |-> !LATCH_CLK_O;
    endproperty
    a_rst_div_low: assert property (p_rst_div_low)
        else $error("divided clock high in interleave reset");
    property p_rst_sel_i;
        interleave_reset[*5] |-> SEL_O == SEL_I;
    endproperty
    a_rst_sel_i: assert property (p_rst_sel_i)
        else $error("select not forced to I in interleave reset");
    property p_dual_no_div;
        MODE_DUAL_O |-> !LATCH_CLK_O;
    endproperty
    a_dual_no_div: assert property (p_dual_no_div)
        else $error("divided clock runs in dual mode");
    property p_mode_follow;
        $stable(mode_sel)[*6] |-> MODE_DUAL_O == mode_sel;
    endproperty
    a_mode_follow: assert property (p_mode_follow)
        else $error("synced mode differs from mode pin");
    property p_tie_a;
        update_clock_chan_a == write_strobe_chan_a;
    endproperty
    a_tie_a: assert property (p_tie_a)
        else $error("clock A not tied to write A");
    property p_tie_b;
        update_clock_chan_b == write_strobe_chan_b;
    endproperty
    a_tie_b: assert property (p_tie_b)
        else $error("clock B not tied to write B");
    property p_twos;
        UPD_O[0] |-> DAC_I_TC_O == (DAC_I_O ^ MSB_MASK);
    endproperty
    a_twos: assert property (p_twos)
        else $error("two's complement view wrong");
    property p_twos_q;
        UPD_O[1] |-> DAC_Q_TC_O == (DAC_Q_O ^ MSB_MASK);
    endproperty
    a_twos_q: assert property (p_twos_q)
        else $error("Q two's complement view wrong");
    property p_clk_lead_a;
        $rose(write_strobe_chan_a) |-> update_clock_chan_a;
    endproperty
    a_clk_lead_a: assert property (p_clk_lead_a)
        else $error("clock A rose after write A");
    property p_q_hold;
        $changed(DAC_Q_O) |-> UPD_O[1];
    endproperty
    a_q_hold: assert property (p_q_hold)
        else $error("Q output moved without update");
    property p_wr_wide;
        $rose(write_strobe_chan_a) |=> write_strobe_chan_a;
    endproperty
    a_wr_wide: assert property (p_wr_wide)
        else $error("write strobe high for one cycle only");
endmodule : ddp_link_checker

// file: dv/dual_dac_parallel_input_port_tb.sv
`timescale 1ns/1ps
module dual_dac_parallel_input_port_tb;
    import ddp_pkg::*;
    logic              sys_clk  = 1'b0;
    logic              arst_n   = 1'b0;
    logic              mode     = MODE_DUAL;
    logic              resync   = 1'b0;
    logic [23:0]       pair     = 24'h000000;
    logic              pair_vld = 1'b0;
    logic              pair_rdy;
    logic [11:0]       dac_i, dac_q, tc_i, tc_q, di_p, dq_p, lb;
    logic [1:0]        upd;
    logic              lclk, sel, mdual, wa_p, wb_p;
    int                err_count   = 0;
    int                check_count = 0;
    int                ra = 0, rb = 0, n, k, p;
    int                ca[logic [11:0]];
    int                cb[logic [11:0]];
    logic [11:0]       pq[logic [11:0]];

    always #5 sys_clk = ~sys_clk;

    ddp_link_if i_ddp_link_if ();
    ddp_host i_ddp_host (.SYS_CLK_I(sys_clk), .ARST_N_I(arst_n),
        .MODE_I(mode), .RESYNC_I(resync), .PAIR_I(pair),
        .PAIR_VALID_I(pair_vld), .PAIR_READY_O(pair_rdy),
        .LINK(i_ddp_link_if));
    ddp_dev i_ddp_dev (.SYS_CLK_I(sys_clk), .ARST_N_I(arst_n),
        .LINK(i_ddp_link_if), .DAC_I_O(dac_i), .DAC_Q_O(dac_q),
        .DAC_I_TC_O(tc_i), .DAC_Q_TC_O(tc_q), .UPD_O(upd),
        .LATCH_CLK_O(lclk), .SEL_O(sel), .MODE_DUAL_O(mdual));
    ddp_link_checker i_ddp_link_checker (.SYS_CLK_I(sys_clk),
        .ARST_N_I(arst_n),
        .write_strobe_chan_a(i_ddp_link_if.write_strobe_chan_a),
        .write_strobe_chan_b(i_ddp_link_if.write_strobe_chan_b),
        .update_clock_chan_a(i_ddp_link_if.update_clock_chan_a),
        .update_clock_chan_b(i_ddp_link_if.update_clock_chan_b),
        .interleave_reset(i_ddp_link_if.interleave_reset),
        .mode_sel(i_ddp_link_if.mode_sel), .DAC_I_O(dac_i),
        .DAC_Q_O(dac_q), .DAC_I_TC_O(tc_i), .DAC_Q_TC_O(tc_q),
        .UPD_O(upd), .LATCH_CLK_O(lclk), .SEL_O(sel), .MODE_DUAL_O(mdual));

    task automatic chk(input string nm, input logic [11:0] e,
                       input logic [11:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // Entered at a rising edge; valid stays up for back-to-back use
    task automatic send(input logic [11:0] i, input logic [11:0] q);
        pair <= {q, i};
        pair_vld <= 1'b1;
        pq[i] = q;
        for (int j = 0; j < 300; j++) begin
            @(negedge sys_clk);
            if (pair_rdy === 1'b1) break;
        end
        @(posedge sys_clk);
    endtask : send

    task automatic wait_out(input logic [11:0] i, input logic [11:0] q);
        for (int j = 0; j < 800; j++) begin
            @(negedge sys_clk);
            if (dac_i === i && dac_q === q) break;
        end
        chk("dac_i", i, dac_i);
        chk("dac_q", q, dac_q);
    endtask : wait_out

    // Resync forgets old captures, as stale words would skew latency
    task automatic set_mode(input logic m);
        @(posedge sys_clk);
        mode <= m;
        resync <= 1'b1;
        @(posedge sys_clk);
        resync <= 1'b0;
        repeat (40) @(posedge sys_clk);
        ca.delete();
        cb.delete();
        pq.delete();
    endtask : set_mode

    // Link watch: rise count at each word's first capture
    always @(negedge sys_clk) begin
        if (i_ddp_link_if.write_strobe_chan_a === 1'b1 && !wa_p) begin
            ra++;
            if (!ca.exists(i_ddp_link_if.bus_a)) ca[i_ddp_link_if.bus_a] = ra;
        end
        if (i_ddp_link_if.write_strobe_chan_b === 1'b1 && !wb_p) begin
            rb++;
            if (!cb.exists(i_ddp_link_if.bus_b)) cb[i_ddp_link_if.bus_b] = rb;
        end
        if (mdual === 1'b1 && dac_i !== di_p && ca.exists(dac_i))
            chk("lat_a", 12'(LAT_CYC), 12'(ra - ca[dac_i]));
        if (mdual === 1'b1 && dac_q !== dq_p && cb.exists(dac_q))
            chk("lat_b", 12'(LAT_CYC), 12'(rb - cb[dac_q]));
        if (mdual === 1'b0 && upd[0] === 1'b1 && pq.exists(dac_i))
            chk("pair_q", pq[dac_i], dac_q);
        wa_p = i_ddp_link_if.write_strobe_chan_a === 1'b1;
        wb_p = i_ddp_link_if.write_strobe_chan_b === 1'b1;
        di_p = dac_i;
        dq_p = dac_q;
    end

    // Cut a hang well past the expected thousand or so cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        $display("MISMATCH watchdog exp done got timeout");
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (20) @(posedge sys_clk);
        send(12'h800, 12'h7FF);
        send(12'hFFF, 12'h001);
        send(12'h001, 12'hFFF);
        send(12'h7FF, 12'h800);
        pair_vld <= 1'b0;
        wait_out(12'h7FF, 12'h800);
        $display("test dual_codes done");
        // Push every cycle until the buffer refuses; pops seen on bus A
        @(posedge sys_clk);
        n = 0;
        p = 0;
        lb = i_ddp_link_if.bus_a;
        pair <= {12'h100, 12'h200};
        pair_vld <= 1'b1;
        for (k = 0; k < 60; k++) begin
            @(negedge sys_clk);
            if (i_ddp_link_if.bus_a !== lb) p++;
            lb = i_ddp_link_if.bus_a;
            if (pair_rdy !== 1'b1) break;
            @(posedge sys_clk);
            n++;
            pair <= {12'h100 + 12'(n), 12'h200 + 12'(n)};
        end
        @(posedge sys_clk);
        pair_vld <= 1'b0;
        // Held words when refused: pushes less pops, exactly the depth
        chk("fill", 12'(FIFO_DEPTH), 12'(n - p));
        wait_out(12'h200 + 12'(n - 1), 12'h100 + 12'(n - 1));
        $display("test fill_drain done");
        set_mode(MODE_IQ);
        send(12'h0A1, 12'h0B1);
        send(12'h0A2, 12'h0B2);
        send(12'h0A3, 12'h0B3);
        pair_vld <= 1'b0;
        wait_out(12'h0A3, 12'h0B3);
        set_mode(MODE_IQ);
        send(12'h0C4, 12'h0D4);
        pair_vld <= 1'b0;
        wait_out(12'h0C4, 12'h0D4);
        $display("test interleaved done");
        set_mode(MODE_DUAL);
        send(12'h0E5, 12'h0F5);
        pair_vld <= 1'b0;
        wait_out(12'h0E5, 12'h0F5);
        $display("test back_to_dual done");
        report_and_stop();
    end
endmodule : dual_dac_parallel_input_port_tb
